// ==== pkg/capture_record_pkg.sv ====
// Shared constants for the capture record formatter
package capture_record_pkg;

   // Register byte addresses
   localparam logic [11:0] CTRL_ADDR = 12'h000;
   localparam logic [11:0] STATUS_ADDR = 12'h004;
   localparam logic [11:0] INT_STATUS_ADDR = 12'h008;
   localparam logic [11:0] INT_MASK_ADDR = 12'h00c;
   localparam logic [11:0] SEC_SET_ADDR = 12'h010;
   localparam logic [11:0] TIME_SEC_ADDR = 12'h014;
   localparam logic [11:0] TIME_FRAC_ADDR = 12'h018;
   localparam logic [11:0] SNAP_LEN_ADDR = 12'h01c;

   // Control register fields
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_VARLEN_BIT = 1;
   localparam int CTRL_TYPE_LSB = 8;
   localparam int CTRL_IFACE_LSB = 12;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0202;
   localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000_3703;
   localparam logic [31:0] SNAP_RESET = 32'h0000_0800;

   // Interrupt status bits
   localparam int EV_RECORD_BIT = 0;
   localparam int EV_DROP_BIT = 1;
   localparam int EV_TRUNC_BIT = 2;
   localparam int EV_RXERR_BIT = 3;
   localparam int EV_COUNT = 4;

   // Record type codes
   localparam logic [7:0] LEGACY_CODE = 8'h00;
   localparam logic [7:0] HDLC_POS_CODE = 8'h01;
   localparam logic [7:0] ethernet_record_code = 8'h02;
   localparam logic [7:0] CELL_CODE = 8'h03;
   localparam logic [7:0] reassembled_cell_frame_code = 8'h04;
   localparam logic [7:0] multichannel_hdlc_code = 8'h05;
   localparam logic [7:0] multichannel_raw_code = 8'h06;
   localparam logic [7:0] multichannel_cell_code = 8'h07;

   // Flags byte layout
   localparam int FLAG_IFACE_LSB = 0;
   localparam int FLAG_VARLEN_BIT = 2;
   localparam int FLAG_TRUNC_BIT = 3;
   localparam int FLAG_RXERR_BIT = 4;
   localparam int internal_fault_flag = 5;

   // Record geometry
   localparam logic [15:0] HEADER_BYTES = 16'h0010;
   localparam logic [15:0] ETH_PREFIX_BYTES = 16'h0002;
   localparam logic [15:0] HEADER_WORDS = 16'h0004;
   localparam logic [15:0] LOSS_MAX = 16'hffff;
   localparam logic [7:0] ETH_OFFSET_VALUE = 8'h00;
   localparam logic [7:0] ETH_PAD_VALUE = 8'h00;

   // Timestamp clock: 2^32 / 125e6 fraction units per cycle, rounded
   localparam logic [31:0] FRAC_STEP_DEFAULT = 32'h0000_0022;
   localparam int ZERO_BITS_DEFAULT = 2;

endpackage : capture_record_pkg

// ==== core/timestamp_clock.sv ====
// Free-running 64-bit seconds.fraction arrival clock
module timestamp_clock #(
   parameter logic [31:0] FRAC_STEP = capture_record_pkg::FRAC_STEP_DEFAULT,
   parameter int ZERO_BITS = capture_record_pkg::ZERO_BITS_DEFAULT
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic loadSec,
   input wire logic [31:0] secValue,
   output logic [63:0] nowTime
);

   initial
   begin
      if (ZERO_BITS < 0 || ZERO_BITS > 31) $error("ZERO_BITS out of range");
   end

   typedef struct packed {
      logic [31:0] sec;
      logic [31:0] frac;
      logic [63:0] now;
   } clk_state_t;

   localparam logic [31:0] FRAC_MASK = ~((32'h0000_0001 << ZERO_BITS) - 32'h0000_0001);

   clk_state_t s_q;
   clk_state_t s_d;
   logic [32:0] fracSum;

   always_comb
   begin
      s_d = s_q;
      fracSum = {1'b0, s_q.frac} + {1'b0, FRAC_STEP};
      // Whole seconds carry out of the binary fraction
      s_d.frac = fracSum[31:0];
      s_d.sec = s_q.sec + {31'h0000_0000, fracSum[32]};
      if (loadSec)
      begin
         s_d.sec = secValue;
         s_d.frac = 32'h0000_0000;
      end
      s_d.now = {s_d.sec, s_d.frac & FRAC_MASK};
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign nowTime = s_q.now;

endmodule : timestamp_clock

// ==== core/capture_record_formatter.sv ====
// Capture record formatter: frame buffer, record header builder, APB registers
// Behaviour
// - Header fields big-endian on the bus; timestamp least significant byte first.
// - Record: timestamp, type/flags/length, loss/wire length, then length-16 body bytes.
// - Type byte carries the frame subtype code 0 to 7.
// - Flags bits 1-0 hold interface number; bits 7-6 reserved zero.
// - Flags bit2 varying lengths, bit3 truncated, bit4 link error, bit5 internal error.
// - Record length counts every byte transferred, header included.
// - Sixteen-bit loss count of frames dropped since the previous record was captured.
// - Loss count starts at zero and sticks at 0xffff.
// - Wire length reports the frame length seen on the line.
// - Capture offset byte holds no meaning; consumers ignore it.
// - Ethernet records use code 2, add offset and pad, then length-18 frame bytes.
// - Frame bytes follow the pad byte directly, keeping network header word aligned.
// - Payload copied in arrival order with no byte reordering.
// - Timestamp is 32-bit seconds above 32-bit binary fraction.
// - Seconds count referenced to 1970 epoch, loaded by software.
// - Timestamp captured when the frame's first byte arrives.
// - Fraction bits below implemented resolution are forced to zero.
//
// The implementer's own choices: the address map and register access over APB.
module capture_record_formatter #(
   parameter int BUF_ADDR_W = 11,
   parameter logic [31:0] FRAC_STEP = capture_record_pkg::FRAC_STEP_DEFAULT,
   parameter int ZERO_BITS = capture_record_pkg::ZERO_BITS_DEFAULT
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   input wire logic rxSof,
   input wire logic rxEof,
   input wire logic rxLinkErr,
   input wire logic rxIntErr,
   output logic outValid,
   output logic [31:0] outData,
   output logic outLast,
   input wire logic outReady,
   output logic irq
);

   initial
   begin
      if (BUF_ADDR_W < 4 || BUF_ADDR_W > 14) $error("BUF_ADDR_W out of range");
   end

   localparam int BUF_BYTES = 1 << BUF_ADDR_W;
   localparam logic [15:0] BUF_MAX = 16'(BUF_BYTES);

   localparam int EV_COUNT_W = capture_record_pkg::EV_COUNT;

   typedef enum logic [1:0] {CAP_IDLE, CAP_RUN, CAP_HOLD} cap_state_t;

   typedef struct packed {
      cap_state_t cap;
      logic [15:0] stored;
      logic [15:0] wireLen;
      logic [63:0] stamp;
      logic trunc;
      logic linkErr;
      logic intErr;
      logic [15:0] loss;
      logic [15:0] lossRec;
      logic [7:0] typeRec;
      logic [7:0] flagsRec;
      logic [15:0] rlenRec;
      logic [15:0] wordIdx;
      logic outValid;
      logic [31:0] outData;
      logic outLast;
      logic [31:0] ctrl;
      logic [31:0] snap;
      logic [EV_COUNT_W-1:0] intStat;
      logic [EV_COUNT_W-1:0] intMask;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic irq;
   } fmt_state_t;

   fmt_state_t s_q;
   fmt_state_t s_d;
   logic [7:0] bufMem [BUF_BYTES];
   logic bufWrite;
   logic [BUF_ADDR_W-1:0] bufAddr;
   logic [63:0] nowTime;
   logic loadSec;

   timestamp_clock #(
      .FRAC_STEP(FRAC_STEP),
      .ZERO_BITS(ZERO_BITS)
   ) u_clock (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .loadSec(loadSec),
      .secValue(pwdata),
      .nowTime(nowTime)
   );

   // Body byte k of the record after the header
   function automatic logic [7:0] body_byte(input logic [15:0] k, input logic eth, input logic [15:0] stored);
      logic [15:0] src;
      logic [7:0] b;
      src = k;
      b = 8'h00;
      if (eth)
      begin
         if (k == 16'h0000)
            b = capture_record_pkg::ETH_OFFSET_VALUE;
         else if (k == 16'h0001)
            b = capture_record_pkg::ETH_PAD_VALUE;
         src = k - capture_record_pkg::ETH_PREFIX_BYTES;
      end
      if ((!eth || k >= capture_record_pkg::ETH_PREFIX_BYTES) && src < stored)
         b = bufMem[src[BUF_ADDR_W-1:0]];
      return b;
   endfunction : body_byte

   // Assemble bus word idx of the pending record
   function automatic logic [31:0] record_word(input fmt_state_t st);
      logic [31:0] w;
      logic [15:0] base;
      logic eth;
      w = 32'h0000_0000;
      base = 16'((st.wordIdx - capture_record_pkg::HEADER_WORDS) << 2);
      eth = (st.typeRec == capture_record_pkg::ethernet_record_code);
      unique case (st.wordIdx)
         16'h0000: w = st.stamp[31:0];
         16'h0001: w = st.stamp[63:32];
         16'h0002: w = {st.rlenRec[7:0], st.rlenRec[15:8], st.flagsRec, st.typeRec};
         16'h0003: w = {st.wireLen[7:0], st.wireLen[15:8], st.lossRec[7:0], st.lossRec[15:8]};
         default:
         begin
            for (int j = 0; j < 4; j++)
               w[8*j +: 8] = body_byte(base + 16'(j), eth, st.stored);
         end
      endcase
      return w;
   endfunction : record_word

   logic apbAccess;
   logic apbDone;
   logic [EV_COUNT_W-1:0] events;
   logic [15:0] bodyBytes;
   logic [15:0] rlenRaw;
   logic [15:0] lastWord;
   logic capStart;
   logic capByte;
   logic capEnd;
   logic isEth;
   logic advance;

   always_comb
   begin
      s_d = s_q;
      events = '0;
      bufWrite = 1'b0;
      bufAddr = s_q.stored[BUF_ADDR_W-1:0];
      loadSec = 1'b0;
      isEth = (s_q.ctrl[capture_record_pkg::CTRL_TYPE_LSB +: 3] == capture_record_pkg::ethernet_record_code[2:0]);

      // Capture side
      capStart = rxValid && rxSof;
      capByte = 1'b0;
      capEnd = 1'b0;
      if (capStart && (s_q.cap != CAP_IDLE || !s_q.ctrl[capture_record_pkg::CTRL_ENABLE_BIT]))
      begin
         // Single record buffer busy or capture off: frame lost
         if (s_q.cap != CAP_RUN || !rxEof)
            events[capture_record_pkg::EV_DROP_BIT] = s_q.ctrl[capture_record_pkg::CTRL_ENABLE_BIT];
         if (s_q.loss != capture_record_pkg::LOSS_MAX && s_q.ctrl[capture_record_pkg::CTRL_ENABLE_BIT])
            s_d.loss = s_q.loss + 16'h0001;
      end
      else if (capStart)
      begin
         s_d.cap = CAP_RUN;
         s_d.stamp = nowTime;
         s_d.stored = 16'h0000;
         s_d.wireLen = 16'h0000;
         s_d.trunc = 1'b0;
         s_d.linkErr = 1'b0;
         s_d.intErr = 1'b0;
         capByte = 1'b1;
         bufAddr = '0;
      end
      else if (rxValid && s_q.cap == CAP_RUN)
         capByte = 1'b1;

      if (capByte)
      begin
         if (s_d.wireLen != 16'hffff)
            s_d.wireLen = s_d.wireLen + 16'h0001;
         if (s_d.stored < s_q.snap[15:0] && s_d.stored < BUF_MAX)
         begin
            bufWrite = 1'b1;
            s_d.stored = s_d.stored + 16'h0001;
         end
         else
            s_d.trunc = 1'b1;
         s_d.linkErr = s_d.linkErr | rxLinkErr;
         s_d.intErr = s_d.intErr | rxIntErr;
         capEnd = rxEof;
      end

      bodyBytes = s_d.stored + (isEth ? capture_record_pkg::ETH_PREFIX_BYTES : 16'h0000);
      rlenRaw = capture_record_pkg::HEADER_BYTES + bodyBytes;
      if (capEnd)
      begin
         s_d.cap = CAP_HOLD;
         s_d.typeRec = {5'h00, s_q.ctrl[capture_record_pkg::CTRL_TYPE_LSB +: 3]};
         s_d.flagsRec = '0;
         s_d.flagsRec[capture_record_pkg::FLAG_IFACE_LSB +: 2] = s_q.ctrl[capture_record_pkg::CTRL_IFACE_LSB +: 2];
         s_d.flagsRec[capture_record_pkg::FLAG_VARLEN_BIT] = s_q.ctrl[capture_record_pkg::CTRL_VARLEN_BIT];
         s_d.flagsRec[capture_record_pkg::FLAG_TRUNC_BIT] = s_d.trunc;
         s_d.flagsRec[capture_record_pkg::FLAG_RXERR_BIT] = s_d.linkErr;
         s_d.flagsRec[capture_record_pkg::internal_fault_flag] = s_d.intErr;
         // Whole bus words are transferred, so the length counts the tail padding
         s_d.rlenRec = (rlenRaw + 16'h0003) & 16'hfffc;
         s_d.lossRec = s_q.loss;
         s_d.loss = 16'h0000;
         s_d.wordIdx = 16'h0000;
         events[capture_record_pkg::EV_TRUNC_BIT] = s_d.trunc;
         events[capture_record_pkg::EV_RXERR_BIT] = s_d.linkErr;
      end

      // Output side: registered word stream with back-pressure
      lastWord = (s_q.rlenRec >> 2) - 16'h0001;
      advance = !s_q.outValid || outReady;
      if (s_q.outValid && outReady && s_q.outLast)
      begin
         s_d.cap = CAP_IDLE;
         events[capture_record_pkg::EV_RECORD_BIT] = 1'b1;
      end
      if (advance)
      begin
         s_d.outValid = 1'b0;
         s_d.outLast = 1'b0;
         if (s_q.cap == CAP_HOLD && !(s_q.outValid && s_q.outLast))
         begin
            s_d.outValid = 1'b1;
            s_d.outData = record_word(s_q);
            s_d.outLast = (s_q.wordIdx == lastWord);
            s_d.wordIdx = s_q.wordIdx + 16'h0001;
         end
      end

      // APB slave: one wait state, effects at the completing edge
      apbAccess = psel && penable;
      apbDone = apbAccess && s_q.pready;
      s_d.pready = apbAccess && !s_q.pready;
      if (apbAccess && !s_q.pready)
      begin
         s_d.pslverr = 1'b0;
         s_d.prdata = 32'h0000_0000;
         unique case (paddr)
            capture_record_pkg::CTRL_ADDR: s_d.prdata = s_q.ctrl;
            capture_record_pkg::STATUS_ADDR: s_d.prdata = {s_q.loss, 14'h0000, 2'(s_q.cap)};
            capture_record_pkg::INT_STATUS_ADDR: s_d.prdata = 32'(s_q.intStat);
            capture_record_pkg::INT_MASK_ADDR: s_d.prdata = 32'(s_q.intMask);
            capture_record_pkg::SEC_SET_ADDR: s_d.prdata = 32'h0000_0000;
            capture_record_pkg::TIME_SEC_ADDR: s_d.prdata = nowTime[63:32];
            capture_record_pkg::TIME_FRAC_ADDR: s_d.prdata = nowTime[31:0];
            capture_record_pkg::SNAP_LEN_ADDR: s_d.prdata = s_q.snap;
            default: s_d.pslverr = 1'b1;
         endcase
      end
      else if (!apbAccess)
      begin
         s_d.pslverr = 1'b0;
      end

      // Sticky events: a new event wins over a write-one clear
      s_d.intStat = s_q.intStat;
      if (apbDone && pwrite)
      begin
         unique case (paddr)
            capture_record_pkg::CTRL_ADDR: s_d.ctrl = pwdata & capture_record_pkg::CTRL_WRITE_MASK;
            capture_record_pkg::INT_STATUS_ADDR: s_d.intStat = s_q.intStat & ~pwdata[EV_COUNT_W-1:0];
            capture_record_pkg::INT_MASK_ADDR: s_d.intMask = pwdata[EV_COUNT_W-1:0];
            capture_record_pkg::SEC_SET_ADDR: loadSec = 1'b1;
            capture_record_pkg::SNAP_LEN_ADDR: s_d.snap = {16'h0000, pwdata[15:0]};
            default: s_d.intStat = s_q.intStat;
         endcase
      end
      s_d.intStat = s_d.intStat | events;
      s_d.irq = |(s_d.intStat & s_d.intMask);
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_q <= '0;
         s_q.cap <= CAP_IDLE;
         s_q.ctrl <= capture_record_pkg::CTRL_RESET;
         s_q.snap <= capture_record_pkg::SNAP_RESET;
      end
      else
         s_q <= s_d;
   end

   // Frame byte store, written in arrival order
   always_ff @(posedge ref_clk)
   begin
      if (bufWrite)
         bufMem[bufAddr] <= rxData;
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign outValid = s_q.outValid;
   assign outData = s_q.outData;
   assign outLast = s_q.outLast;
   assign irq = s_q.irq;

endmodule : capture_record_formatter

// ==== tb/capture_record_formatter_props.sv ====
// Checker for the capture record formatter output and APB ports
module capture_record_formatter_props #(
   parameter int ZERO_BITS = 2
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic outValid,
   input wire logic [31:0] outData,
   input wire logic outLast,
   input wire logic outReady
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] idx_q;
   logic [15:0] rlen_q;
   logic eth_q;

   // Word position within the current record
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         idx_q <= 8'h00;
         rlen_q <= 16'h0000;
         eth_q <= 1'b0;
      end
      else if (outValid && outReady)
      begin
         idx_q <= outLast ? 8'h00 : idx_q + 8'h01;
         if (idx_q == 8'h02)
         begin
            rlen_q <= {outData[23:16], outData[31:24]};
            eth_q <= outData[7:0] == 8'h02;
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   property p_frac;
      outValid && idx_q == 8'h00 |-> (outData & ((32'h1 << ZERO_BITS) - 32'h1)) == 32'h0;
   endproperty
   a_frac: assert property (p_frac)
      else $error("fraction low bits set");
   property p_flagres;
      outValid && idx_q == 8'h02 |-> outData[15:14] == 2'h0;
   endproperty
   a_flagres: assert property (p_flagres)
      else $error("reserved flag bits set");
   property p_type;
      outValid && idx_q == 8'h02 |-> outData[7:0] <= 8'h07;
   endproperty
   a_type: assert property (p_type)
      else $error("type code out of range");
   property p_rlenfmt;
      outValid && idx_q == 8'h02 |-> {outData[23:16], outData[31:24]} >= 16'h10 && outData[25:24] == 2'h0;
   endproperty
   a_rlenfmt: assert property (p_rlenfmt)
      else $error("record length malformed");
   property p_last;
      outValid && idx_q > 8'h02 |-> outLast == ({6'h0, idx_q, 2'h0} + 16'h4 == rlen_q);
   endproperty
   a_last: assert property (p_last)
      else $error("last word disagrees with length");
   property p_stall;
      outValid && !outReady |=> outValid && $stable(outData) && $stable(outLast);
   endproperty
   a_stall: assert property (p_stall)
      else $error("word changed while stalled");
   property p_pad;
      outValid && eth_q && idx_q == 8'h04 |-> outData[15:8] == 8'h00;
   endproperty
   a_pad: assert property (p_pad)
      else $error("pad byte not zero");
   property p_apb;
      psel && penable && !pready |=> pready;
   endproperty
   a_apb: assert property (p_apb)
      else $error("apb wait state missing");
endmodule : capture_record_formatter_props

// ==== tb/host_memory_model.sv ====
// Host memory sink taking record words, prompt, slow or stalled
module host_memory_model (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic hold,
   input wire logic slow,
   input wire logic outValid,
   input wire logic [31:0] outData,
   input wire logic outLast,
   output logic outReady
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [0:63];
   logic [5:0] wptr_q;
   logic [1:0] cnt_q;
   int recs_q;

   assign outReady = !hold && (!slow || cnt_q == 2'h0);

   // Offset byte stored as is, never interpreted
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wptr_q <= 6'h00;
         cnt_q <= 2'h0;
         recs_q <= 0;
      end
      else
      begin
         cnt_q <= cnt_q + 2'h1;
         if (outValid && outReady)
         begin
            mem[wptr_q] <= outData;
            wptr_q <= outLast ? 6'h00 : wptr_q + 6'h01;
            if (outLast)
               recs_q <= recs_q + 1;
         end
      end
   end
endmodule : host_memory_model

// ==== tb/capture_record_formatter_bench.sv ====
// Testbench for the capture record formatter
module capture_record_formatter_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, er, hold, slow;
   logic rxValid, rxSof, rxEof, rxLinkErr, rxIntErr, outValid, outLast, outReady, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, outData, rd;
   logic [7:0] rxData;
   int err_total, checks_done;

   capture_record_formatter DUT (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rxValid(rxValid), .rxData(rxData), .rxSof(rxSof), .rxEof(rxEof), .rxLinkErr(rxLinkErr),
      .rxIntErr(rxIntErr), .outValid(outValid), .outData(outData), .outLast(outLast), .outReady(outReady),
      .irq(irq));
   host_memory_model host (.ref_clk(ref_clk), .arst_n(arst_n), .hold(hold), .slow(slow),
      .outValid(outValid), .outData(outData), .outLast(outLast), .outReady(outReady));

   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task stop_test;
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         err_total++;
         stop_test;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task frame(input int n, input logic le, input logic ie);
      for (int i = 0; i < n; i++)
      begin
         @(posedge ref_clk);
         rxValid <= 1'b1;
         rxData <= 8'h10 + 8'(i);
         rxSof <= i == 0;
         rxEof <= i == n - 1;
         rxLinkErr <= le;
         rxIntErr <= ie;
      end
      @(posedge ref_clk);
      rxValid <= 1'b0;
      rxSof <= 1'b0;
      rxEof <= 1'b0;
   endtask : frame

   task wait_rec;
      int n, c;
      n = 0;
      c = host.recs_q;
      while (host.recs_q == c && n < 3000)
      begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 3000)
      begin
         err_total++;
         stop_test;
      end
      repeat (2) @(posedge ref_clk);
   endtask : wait_rec

   initial
   begin
      err_total = 0;
      checks_done = 0;
      arst_n = 1'b0;
      {psel, penable, pwrite, hold, rxValid, rxSof, rxEof, rxLinkErr, rxIntErr} = 9'h000;
      slow = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0;
      rxData = 8'h00;
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;
      apb(1'b0, capture_record_pkg::CTRL_ADDR, 32'h0);
      chk("ctrl reset", capture_record_pkg::CTRL_RESET, rd);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped", 32'h1, {31'h0, er});
      apb(1'b1, capture_record_pkg::INT_MASK_ADDR, 32'h1);
      apb(1'b1, capture_record_pkg::SEC_SET_ADDR, 32'h5);
      apb(1'b1, capture_record_pkg::CTRL_ADDR, 32'h0000_1203);
      frame(6, 1'b0, 1'b0);
      wait_rec;
      chk("ts seconds", 32'h5, host.mem[1]);
      chk("ts frac", 32'h0, host.mem[0] & 32'h3);
      chk("header", 32'h1800_0502, host.mem[2]);
      chk("lengths", 32'h0600_0000, host.mem[3]);
      chk("eth prefix", 32'h1110_0000, host.mem[4] & 32'hffff_ff00);
      chk("body", 32'h1514_1312, host.mem[5]);
      chk("irq set", 32'h1, {31'h0, irq});
      apb(1'b1, capture_record_pkg::INT_STATUS_ADDR, 32'hf);
      apb(1'b0, capture_record_pkg::INT_STATUS_ADDR, 32'h0);
      chk("irq clear", 32'h0, {31'h0, irq});
      apb(1'b1, capture_record_pkg::INT_MASK_ADDR, 32'h0);
      hold <= 1'b1;
      frame(2, 1'b0, 1'b0);
      frame(2, 1'b0, 1'b0);
      apb(1'b0, capture_record_pkg::STATUS_ADDR, 32'h0);
      chk("loss count", 32'h1, rd >> 16);
      hold <= 1'b0;
      wait_rec;
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b0, capture_record_pkg::INT_STATUS_ADDR, 32'h0);
      chk("drop event", 32'h2, rd & 32'h2);
      slow <= 1'b0;
      frame(2, 1'b0, 1'b0);
      wait_rec;
      chk("loss field", 32'h0200_0100, host.mem[3]);
      for (int t = 0; t < 8; t++)
      begin
         apb(1'b1, capture_record_pkg::CTRL_ADDR, 32'h0000_1003 | (32'(t) << 8));
         frame(1, 1'b0, 1'b0);
         wait_rec;
         chk("type header", {24'h14_0005, 8'(t)}, host.mem[2]);
      end
      apb(1'b1, capture_record_pkg::SNAP_LEN_ADDR, 32'h4);
      apb(1'b1, capture_record_pkg::CTRL_ADDR, 32'h0000_1101);
      frame(9, 1'b1, 1'b1);
      wait_rec;
      chk("trunc header", 32'h1400_3901, host.mem[2]);
      chk("trunc wlen", 32'h0900_0000, host.mem[3]);
      stop_test;
   end
endmodule : capture_record_formatter_bench

bind capture_record_formatter capture_record_formatter_props #(.ZERO_BITS(ZERO_BITS)) props (.ref_clk(ref_clk),
   .arst_n(arst_n), .psel(psel), .penable(penable), .pready(pready), .outValid(outValid), .outData(outData),
   .outLast(outLast), .outReady(outReady));
